// [pkg/core_impl_pkg.sv]
// constants, types and register map of the implementation-dependency control block
package core_impl_pkg;

   // register indices on the plain register port
   localparam logic [3:0] CWP_ADDR      = 4'h0;
   localparam logic [3:0] SAVABLE_ADDR  = 4'h1;
   localparam logic [3:0] RESTORE_ADDR  = 4'h2;
   localparam logic [3:0] FOREIGN_ADDR  = 4'h3;
   localparam logic [3:0] CLEAN_ADDR    = 4'h4;
   localparam logic [3:0] CTRL_ADDR     = 4'h5;
   localparam logic [3:0] STAT_ADDR     = 4'h6;

   // control register fields
   localparam int MM_LSB   = 0;
   localparam int MM_W     = 2;
   localparam int AM_BIT   = 2;
   localparam int CLE_BIT  = 3;
   localparam int DATA_MMU_BIT = 4;
   localparam int TL_LSB   = 5;
   localparam int TL_W     = 3;

   // status register fields
   localparam int STAT_FLUSH_BIT = 0;
   localparam int STAT_MM_LSB    = 1;

   // memory models; every selection is served as total store order
   localparam logic [1:0] MM_TSO      = 2'h0;
   localparam logic [1:0] MM_RESERVED = 2'h3;

   // fixed reduced-error-state trap vector
   localparam logic [63:0] RED_TRAP_VA = 64'hFFFF_FFFF_F000_0000;
   localparam logic [63:0] RED_TRAP_PA = 64'h0000_01FF_F000_0000;

   // window state
   localparam int WINDOW_COUNT = 8;
   localparam int WIN_W        = 3;
   localparam int PC_W         = 64;
   localparam int PC_HALF      = 32;

   // cache flush latency once all older instructions have committed
   localparam int FLUSH_CYCLES = 30;

   localparam logic [7:0] RESET_CTRL = 8'h00;

   typedef enum logic [2:0] {
      op_none,
      op_quad_fp_store,
      op_soft_reset,
      op_prefetch,
      op_nf_load,
      op_flush,
      op_pc_write,
      op_mem_access
   } op_t;

   typedef enum logic [1:0] {
      trap_none,
      trap_illegal_instr,
      trap_data_access
   } trap_t;

   typedef enum logic [1:0] {
      asi_primary,
      asi_primary_le,
      asi_kernel,
      asi_kernel_le
   } asi_sel_t;

   typedef struct packed {
      logic              valid;
      op_t               op;
      logic              privileged;
      logic              fpu_enabled;
      logic              side_effect;
      logic              older_done;
      logic [PC_W-1:0]   pc;
   } instr_req_t;

   typedef struct packed {
      logic              commit;
      logic              nop;
      logic              mem_issue;
      logic              stall;
      trap_t             trap;
      logic [PC_W-1:0]   pc_wr_data;
      logic              pc_wr_valid;
   } instr_rsp_t;

endpackage

// [core/core_impl_dependency_control.sv]
// control logic for the implementation-dependent core behaviours
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - the quad floating-point store is not executed; it raises illegal instruction
// - that store never checks or reports the fpu-off trap
// - loads and stores follow total store order whatever the memory model field says
// - reduced-error trap vector is fixed: VA FFFFFFFFF0000000, PA 01FFF0000000
// - software-initiated reset in nonprivileged mode completes as a no-operation
// - no soft reset enable flag exists, no bit stores one
// - with data mmu off, prefetch commits without any memory access
// - with data mmu off, a nonfaulting load raises the data-access exception
// - memory model value 11 binary runs as total store order
// - accesses to side-effect pages are performed strictly in program order
// - cache flush waits for all older instructions, so its latency depends on state
// - after all older instructions commit, flush completes in 30 cycles
// - at trap level above 0 the implicit space is kernel, endian by little-endian bit
// - with address mask bit 1, written pc values have upper 32 bits cleared
// - eight windows; pointer and savable, restorable, foreign counts hold 3 bits
// - window register writes keep only the low 3 bits
// - the clean-window count register is 3 bits wide
// - the fast ecc error trap is never generated
// - no dispatch control register exists; its address reads zero
module core_impl_dependency_control #(
   parameter int DATA_W       = 8,
   parameter int ADDR_W       = 4,
   parameter int WINDOW_COUNT = core_impl_pkg::WINDOW_COUNT,
   parameter int FLUSH_CYCLES = core_impl_pkg::FLUSH_CYCLES
) (
   // clock and reset
   input  wire logic                       mclk_i,
   input  wire logic                       sys_rst_i,
   // register port
   input  wire logic [ADDR_W-1:0]          reg_addr_i,
   input  wire logic [DATA_W-1:0]          reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   output logic      [DATA_W-1:0]          reg_rdata_o,
   // instruction decisions
   input  wire core_impl_pkg::instr_req_t  req_i,
   output core_impl_pkg::instr_rsp_t       rsp_o,
   // flush completion
   output logic                            flush_done_o,
   output logic                            flush_busy_o,
   // memory ordering and address space
   output logic      [1:0]                 mem_model_o,
   output core_impl_pkg::asi_sel_t         implicit_asi_o,
   // window state
   output logic      [core_impl_pkg::WIN_W-1:0] cwp_o,
   output logic      [core_impl_pkg::WIN_W-1:0] savable_window_count_o,
   output logic      [core_impl_pkg::WIN_W-1:0] restorable_window_count_o,
   output logic      [core_impl_pkg::WIN_W-1:0] foreign_window_count_o,
   output logic      [core_impl_pkg::WIN_W-1:0] clean_window_count_o,
   // reduced-error-state vector
   output logic      [core_impl_pkg::PC_W-1:0]  red_vec_va_o,
   output logic      [core_impl_pkg::PC_W-1:0]  red_vec_pa_o
);

   localparam int WIN_W = core_impl_pkg::WIN_W;
   localparam int CNT_W = $clog2(FLUSH_CYCLES + 1);

   // elaboration checks
   if (WINDOW_COUNT != (1 << WIN_W)) begin : g_win_check
      $error("window count must match the 3-bit window registers");
   end
   if (DATA_W < 8 || ADDR_W < 4) begin : g_bus_check
      $error("register port too narrow for the control register map");
   end
   if (FLUSH_CYCLES < 1) begin : g_flush_check
      $error("flush latency must be at least one cycle");
   end

   // keep the low window bits of a write; the upper bits are dropped
   function automatic logic [WIN_W-1:0] win_bits(input logic [DATA_W-1:0] v);
      return v[WIN_W-1:0];
   endfunction

   function automatic logic [DATA_W-1:0] widen(input logic [WIN_W-1:0] v);
      return {{(DATA_W-WIN_W){1'b0}}, v};
   endfunction

   typedef enum logic [1:0] {
      fl_idle,
      fl_wait_older,
      fl_count
   } flush_state_t;

   // register state
   logic [WIN_W-1:0]  cwp_q, cwp_d;
   logic [WIN_W-1:0]  savable_window_count_q, savable_window_count_d;
   logic [WIN_W-1:0]  restorable_window_count_q, restorable_window_count_d;
   logic [WIN_W-1:0]  foreign_window_count_q, foreign_window_count_d;
   logic [WIN_W-1:0]  clean_window_count_q, clean_window_count_d;
   logic [7:0]        ctrl_q, ctrl_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;

   flush_state_t      fl_state_q, fl_state_d;
   logic [CNT_W-1:0]  fl_cnt_q, fl_cnt_d;
   logic              fl_done_q, fl_done_d;

   core_impl_pkg::instr_rsp_t rsp_q, rsp_d;
   logic [1:0]                mm_q;
   core_impl_pkg::asi_sel_t   asi_q, asi_d;

   // register decode
   wire wr_cwp     = reg_wr_i && (reg_addr_i == ADDR_W'(core_impl_pkg::CWP_ADDR));
   wire wr_savable = reg_wr_i && (reg_addr_i == ADDR_W'(core_impl_pkg::SAVABLE_ADDR));
   wire wr_restore = reg_wr_i && (reg_addr_i == ADDR_W'(core_impl_pkg::RESTORE_ADDR));
   wire wr_foreign = reg_wr_i && (reg_addr_i == ADDR_W'(core_impl_pkg::FOREIGN_ADDR));
   wire wr_clean   = reg_wr_i && (reg_addr_i == ADDR_W'(core_impl_pkg::CLEAN_ADDR));
   wire wr_ctrl    = reg_wr_i && (reg_addr_i == ADDR_W'(core_impl_pkg::CTRL_ADDR));

   assign cwp_d        = wr_cwp     ? win_bits(reg_wdata_i) : cwp_q;
   assign savable_window_count_d    = wr_savable ? win_bits(reg_wdata_i) : savable_window_count_q;
   assign restorable_window_count_d = wr_restore ? win_bits(reg_wdata_i) : restorable_window_count_q;
   assign foreign_window_count_d   = wr_foreign ? win_bits(reg_wdata_i) : foreign_window_count_q;
   assign clean_window_count_d   = wr_clean   ? win_bits(reg_wdata_i) : clean_window_count_q;
   // the memory model field keeps what software wrote, 11 binary included
   assign ctrl_d       = wr_ctrl    ? reg_wdata_i[7:0]      : ctrl_q;

   // control fields
   wire [1:0]  mm_field = ctrl_q[core_impl_pkg::MM_LSB +: core_impl_pkg::MM_W];
   wire        am_bit   = ctrl_q[core_impl_pkg::AM_BIT];
   wire        cle_bit  = ctrl_q[core_impl_pkg::CLE_BIT];
   wire        data_mmu_on  = ctrl_q[core_impl_pkg::DATA_MMU_BIT];
   wire [2:0]  tl_field = ctrl_q[core_impl_pkg::TL_LSB +: core_impl_pkg::TL_W];

   // status word: flush activity and the model in force
   wire [DATA_W-1:0] stat_word =
      DATA_W'({core_impl_pkg::MM_TSO, (fl_state_q != fl_idle)});

   // read mux; unmapped addresses, including where a dispatch register would sit, read zero
   assign rdata_d =
      !reg_rd_i                                                  ? '0 :
      (reg_addr_i == ADDR_W'(core_impl_pkg::CWP_ADDR))           ? widen(cwp_q) :
      (reg_addr_i == ADDR_W'(core_impl_pkg::SAVABLE_ADDR))       ? widen(savable_window_count_q) :
      (reg_addr_i == ADDR_W'(core_impl_pkg::RESTORE_ADDR))       ? widen(restorable_window_count_q) :
      (reg_addr_i == ADDR_W'(core_impl_pkg::FOREIGN_ADDR))       ? widen(foreign_window_count_q) :
      (reg_addr_i == ADDR_W'(core_impl_pkg::CLEAN_ADDR))         ? widen(clean_window_count_q) :
      (reg_addr_i == ADDR_W'(core_impl_pkg::CTRL_ADDR))          ? DATA_W'(ctrl_q) :
      (reg_addr_i == ADDR_W'(core_impl_pkg::STAT_ADDR))          ? stat_word :
                                                                   '0;

   // implicit address space
   wire        tl_nonzero = (tl_field != 3'h0);
   assign asi_d = tl_nonzero ? (cle_bit ? core_impl_pkg::asi_kernel_le
                                        : core_impl_pkg::asi_kernel)
                             : (cle_bit ? core_impl_pkg::asi_primary_le
                                        : core_impl_pkg::asi_primary);

   // instruction classification
   wire is_qst   = req_i.valid && (req_i.op == core_impl_pkg::op_quad_fp_store);
   wire is_sir   = req_i.valid && (req_i.op == core_impl_pkg::op_soft_reset);
   wire is_pref  = req_i.valid && (req_i.op == core_impl_pkg::op_prefetch);
   wire is_nfld  = req_i.valid && (req_i.op == core_impl_pkg::op_nf_load);
   wire is_flush = req_i.valid && (req_i.op == core_impl_pkg::op_flush);
   wire is_pcw   = req_i.valid && (req_i.op == core_impl_pkg::op_pc_write);
   wire is_mem   = req_i.valid && (req_i.op == core_impl_pkg::op_mem_access);

   // side-effect access waits until every older instruction has completed
   wire se_hold   = is_mem && req_i.side_effect && !req_i.older_done;
   wire fl_active = (fl_state_q != fl_idle);
   wire fl_finish = (fl_state_q == fl_count) &&
                    (fl_cnt_q == CNT_W'(FLUSH_CYCLES - 1));

   // trap selection; the fast ecc trap has no code and cannot be raised
   wire trap_ill  = is_qst;
   wire trap_dax  = is_nfld && !data_mmu_on;

   // masked pc for destination register writes
   wire [core_impl_pkg::PC_W-1:0] pc_masked =
      am_bit ? {{core_impl_pkg::PC_HALF{1'b0}}, req_i.pc[core_impl_pkg::PC_HALF-1:0]}
             : req_i.pc;

   always_comb begin
      rsp_d             = '0;
      rsp_d.trap        = trap_ill ? core_impl_pkg::trap_illegal_instr :
                          trap_dax ? core_impl_pkg::trap_data_access :
                                     core_impl_pkg::trap_none;
      rsp_d.nop         = is_sir && !req_i.privileged;
      rsp_d.stall       = se_hold || (is_flush && !fl_finish) ||
                          (req_i.valid && fl_active && !is_flush);
      rsp_d.mem_issue   = (is_mem && !se_hold && !fl_active) ||
                          (is_pref && data_mmu_on) ||
                          (is_nfld && data_mmu_on);
      rsp_d.pc_wr_valid = is_pcw;
      rsp_d.pc_wr_data  = is_pcw ? pc_masked : '0;
      rsp_d.commit      = req_i.valid && !trap_ill && !trap_dax && !rsp_d.stall;
   end

   // flush sequencer: waits for older work, then runs the fixed latency
   always_comb begin
      fl_state_d = fl_state_q;
      fl_cnt_d   = fl_cnt_q;
      fl_done_d  = 1'b0;
      unique case (fl_state_q)
         fl_idle: begin
            if (is_flush) begin
               fl_cnt_d   = '0;
               fl_state_d = req_i.older_done ? fl_count : fl_wait_older;
            end
         end
         fl_wait_older: begin
            if (req_i.older_done) begin
               fl_state_d = fl_count;
            end
         end
         fl_count: begin
            fl_cnt_d = fl_cnt_q + CNT_W'(1);
            if (fl_finish) begin
               fl_done_d  = 1'b1;
               fl_cnt_d   = '0;
               fl_state_d = fl_idle;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cwp_q        <= '0;
         savable_window_count_q    <= '0;
         restorable_window_count_q <= '0;
         foreign_window_count_q   <= '0;
         clean_window_count_q   <= '0;
         ctrl_q       <= core_impl_pkg::RESET_CTRL;
         rdata_q      <= '0;
      end else begin
         cwp_q        <= cwp_d;
         savable_window_count_q    <= savable_window_count_d;
         restorable_window_count_q <= restorable_window_count_d;
         foreign_window_count_q   <= foreign_window_count_d;
         clean_window_count_q   <= clean_window_count_d;
         ctrl_q       <= ctrl_d;
         rdata_q      <= rdata_d;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         fl_state_q <= fl_idle;
         fl_cnt_q   <= '0;
         fl_done_q  <= 1'b0;
      end else begin
         fl_state_q <= fl_state_d;
         fl_cnt_q   <= fl_cnt_d;
         fl_done_q  <= fl_done_d;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rsp_q <= '0;
         mm_q  <= core_impl_pkg::MM_TSO;
         asi_q <= core_impl_pkg::asi_primary;
      end else begin
         rsp_q <= rsp_d;
         mm_q  <= core_impl_pkg::MM_TSO;
         asi_q <= asi_d;
      end
   end

   // vector outputs stay at their fixed values from reset on
   logic [core_impl_pkg::PC_W-1:0] red_va_q;
   logic [core_impl_pkg::PC_W-1:0] red_pa_q;
   logic                           fl_busy_q;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         red_va_q  <= core_impl_pkg::RED_TRAP_VA;
         red_pa_q  <= core_impl_pkg::RED_TRAP_PA;
         fl_busy_q <= 1'b0;
      end else begin
         red_va_q  <= core_impl_pkg::RED_TRAP_VA;
         red_pa_q  <= core_impl_pkg::RED_TRAP_PA;
         fl_busy_q <= (fl_state_d != fl_idle);
      end
   end

   assign reg_rdata_o    = rdata_q;
   assign rsp_o          = rsp_q;
   assign flush_done_o   = fl_done_q;
   assign flush_busy_o   = fl_busy_q;
   assign mem_model_o    = mm_q;
   assign implicit_asi_o = asi_q;
   assign cwp_o          = cwp_q;
   assign savable_window_count_o      = savable_window_count_q;
   assign restorable_window_count_o   = restorable_window_count_q;
   assign foreign_window_count_o     = foreign_window_count_q;
   assign clean_window_count_o     = clean_window_count_q;
   assign red_vec_va_o   = red_va_q;
   assign red_vec_pa_o   = red_pa_q;

endmodule // core_impl_dependency_control

`default_nettype wire

// [testbench/core_impl_dependency_control_props.sv]
// assertion checker for the implementation-dependency control block
`timescale 1ns/100ps
`default_nettype none
module core_impl_dependency_control_props #(
   parameter int DATA_W       = 8,
   parameter int ADDR_W       = 4,
   parameter int FLUSH_CYCLES = 30
) (
   input wire logic                      mclk_i,
   input wire logic                      sys_rst_i,
   input wire logic [ADDR_W-1:0]         reg_addr_i,
   input wire logic [DATA_W-1:0]         reg_wdata_i,
   input wire logic                      reg_wr_i,
   input wire logic                      reg_rd_i,
   input wire logic [DATA_W-1:0]         reg_rdata_o,
   input wire core_impl_pkg::instr_req_t req_i,
   input wire core_impl_pkg::instr_rsp_t rsp_o,
   input wire logic                      flush_done_o,
   input wire logic [1:0]                mem_model_o,
   input wire logic [2:0]                cwp_o,
   input wire logic [63:0]               red_vec_va_o,
   input wire logic [63:0]               red_vec_pa_o
);
   logic [31:0] pc_lo;
   logic [2:0]  win_wd;
   assign pc_lo  = req_i.pc[31:0];
   assign win_wd = reg_wdata_i[2:0];

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   a_red_vector_fixed: assert property (
      red_vec_va_o == core_impl_pkg::RED_TRAP_VA && red_vec_pa_o == core_impl_pkg::RED_TRAP_PA)
      else $error("trap vector not constant");
   a_model_always_tso: assert property (mem_model_o == core_impl_pkg::MM_TSO)
      else $error("memory model not total store order");
   a_quad_store_illegal: assert property (
      req_i.valid && req_i.op == core_impl_pkg::op_quad_fp_store |=> !rsp_o.commit &&
      (rsp_o.trap == core_impl_pkg::trap_illegal_instr || rsp_o.stall))
      else $error("quad store not refused as illegal");
   a_soft_reset_nop: assert property (
      req_i.valid && req_i.op == core_impl_pkg::op_soft_reset && !req_i.privileged |=>
      rsp_o.stall || (rsp_o.nop && rsp_o.commit && !rsp_o.mem_issue))
      else $error("soft reset in user mode not a no-op");
   a_data_trap_cause: assert property (
      rsp_o.trap == core_impl_pkg::trap_data_access |-> $past(req_i.op) == core_impl_pkg::op_nf_load)
      else $error("data access trap without nonfaulting load");
   a_pc_low_kept: assert property (rsp_o.pc_wr_valid |-> rsp_o.pc_wr_data[31:0] == $past(pc_lo))
      else $error("written pc low half corrupted");
   a_flush_done_pulse: assert property (
      flush_done_o |-> rsp_o.commit && !rsp_o.stall ##1 !flush_done_o)
      else $error("flush completion malformed");
   a_window_write_trunc: assert property (
      reg_wr_i && reg_addr_i == core_impl_pkg::CWP_ADDR |=> cwp_o == $past(win_wd))
      else $error("window pointer write not truncated");
   a_idle_rdata_zero: assert property (
      !reg_rd_i || reg_addr_i > core_impl_pkg::STAT_ADDR |=> reg_rdata_o == '0)
      else $error("read data not zero");

   c_flush: cover property (flush_done_o);
   c_illegal: cover property (rsp_o.trap == core_impl_pkg::trap_illegal_instr);
   c_data_trap: cover property (rsp_o.trap == core_impl_pkg::trap_data_access);
endmodule // core_impl_dependency_control_props
`default_nettype wire

// [testbench/core_impl_dependency_control_test.sv]
// self-checking bench for the implementation-dependency control block
`timescale 1ns/100ps
`default_nettype none
module core_impl_dependency_control_test;
   localparam int FLUSH_N = 4;
   logic                      mclk_i, sys_rst_i, reg_wr_i, reg_rd_i, flush_done_o, flush_busy_o;
   logic [3:0]                reg_addr_i;
   logic [7:0]                reg_wdata_i, reg_rdata_o;
   core_impl_pkg::instr_req_t req_i;
   core_impl_pkg::instr_rsp_t rsp_o;
   logic [1:0]                mem_model_o;
   core_impl_pkg::asi_sel_t   implicit_asi_o;
   logic [2:0]                cwp_o, savable_window_count_o, restorable_window_count_o, foreign_window_count_o, clean_window_count_o;
   logic [63:0]               red_vec_va_o, red_vec_pa_o;
   int                        err_total, n_compared;

   core_impl_dependency_control #(.FLUSH_CYCLES(FLUSH_N)) uut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_i(req_i),
      .rsp_o(rsp_o), .flush_done_o(flush_done_o), .flush_busy_o(flush_busy_o),
      .mem_model_o(mem_model_o), .implicit_asi_o(implicit_asi_o), .cwp_o(cwp_o),
      .savable_window_count_o(savable_window_count_o), .restorable_window_count_o(restorable_window_count_o), .foreign_window_count_o(foreign_window_count_o),
      .clean_window_count_o(clean_window_count_o), .red_vec_va_o(red_vec_va_o), .red_vec_pa_o(red_vec_pa_o));

   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask

   // flags are privileged, fpu_enabled, side_effect, older_done
   function automatic core_impl_pkg::instr_req_t mk(input core_impl_pkg::op_t op,
                                                    input logic [3:0] f, input logic [63:0] pc);
      core_impl_pkg::instr_req_t r;
      r = '0;
      r.valid = 1'b1;
      r.op = op;
      {r.privileged, r.fpu_enabled, r.side_effect, r.older_done} = f;
      r.pc = pc;
      return r;
   endfunction

   // response is looked at in the one cycle it stands
   task automatic send(input core_impl_pkg::op_t op, input logic [3:0] f, input logic [63:0] pc);
      @(posedge mclk_i);
      req_i <= mk(op, f, pc);
      @(posedge mclk_i);
      req_i <= '0;
      #1;
   endtask

   task automatic t_reset_vals;
      for (int a = 0; a < 5; a++) rd(4'(a), 8'h00);
      chk(red_vec_va_o, 64'hFFFF_FFFF_F000_0000);
      chk(red_vec_pa_o, 64'h0000_01FF_F000_0000);
      chk(implicit_asi_o, core_impl_pkg::asi_primary);
   endtask

   task automatic t_window_regs;
      for (int a = 0; a < 5; a++) wr(4'(a), 8'hFD - 8'(a));
      for (int a = 0; a < 5; a++) rd(4'(a), 8'h05 - 8'(a));
      chk(clean_window_count_o, 3'h1);
      chk({cwp_o, savable_window_count_o, restorable_window_count_o, foreign_window_count_o, clean_window_count_o}, 15'h58D1);
   endtask

   task automatic t_unmapped;
      wr(4'h7, 8'hFF);
      wr(4'hF, 8'hFF);
      wr(4'h6, 8'hFF);
      rd(4'h7, 8'h00);
      rd(4'hF, 8'h00);
      rd(4'h6, 8'h00);
   endtask

   task automatic t_model;
      wr(4'h5, 8'h03);
      rd(4'h5, 8'h03);
      rd(4'h6, 8'h00);
      chk(mem_model_o, 2'h0);
      wr(4'h5, 8'h00);
   endtask

   task automatic t_instr;
      for (int f = 0; f < 2; f++) begin
         send(core_impl_pkg::op_quad_fp_store, {1'b1, 1'(f), 2'b00}, '0);
         chk(rsp_o.trap, core_impl_pkg::trap_illegal_instr);
         chk(rsp_o.commit, 1'b0);
      end
      send(core_impl_pkg::op_soft_reset, 4'h4, '0);
      chk({rsp_o.nop, rsp_o.commit, rsp_o.mem_issue}, 3'b110);
      wr(4'h5, 8'h00);
      send(core_impl_pkg::op_prefetch, 4'h8, '0);
      chk({rsp_o.commit, rsp_o.mem_issue}, 2'b10);
      send(core_impl_pkg::op_nf_load, 4'h8, '0);
      chk(rsp_o.trap, core_impl_pkg::trap_data_access);
      wr(4'h5, 8'h10);
      send(core_impl_pkg::op_nf_load, 4'h8, '0);
      chk({rsp_o.commit, rsp_o.mem_issue, rsp_o.trap}, 4'b1100);
      send(core_impl_pkg::op_mem_access, 4'h2, '0);
      chk({rsp_o.stall, rsp_o.commit}, 2'b10);
      send(core_impl_pkg::op_mem_access, 4'h3, '0);
      chk({rsp_o.stall, rsp_o.commit}, 2'b01);
   endtask

   task automatic t_asi;
      logic [7:0] ctl [4] = '{8'h20, 8'hE8, 8'h08, 8'h00};
      core_impl_pkg::asi_sel_t exp [4] = '{core_impl_pkg::asi_kernel, core_impl_pkg::asi_kernel_le,
                                            core_impl_pkg::asi_primary_le, core_impl_pkg::asi_primary};
      for (int i = 0; i < 4; i++) begin
         wr(4'h5, ctl[i]);
         @(posedge mclk_i);
         #1 chk(implicit_asi_o, exp[i]);
      end
   endtask

   task automatic t_pc_mask;
      wr(4'h5, 8'h04);
      send(core_impl_pkg::op_pc_write, 4'h8, 64'hDEAD_BEEF_1234_5678);
      chk(rsp_o.pc_wr_valid, 1'b1);
      chk(rsp_o.pc_wr_data, 64'h0000_0000_1234_5678);
      wr(4'h5, 8'h00);
      send(core_impl_pkg::op_pc_write, 4'h8, 64'hDEAD_BEEF_1234_5678);
      chk(rsp_o.pc_wr_data, 64'hDEAD_BEEF_1234_5678);
   endtask

   // the request is dropped at the edge the flush is due to finish, so no second flush starts
   task automatic t_flush;
      @(posedge mclk_i);
      req_i <= mk(core_impl_pkg::op_flush, 4'h9, '0);
      for (int n = 1; n <= FLUSH_N; n++) begin
         @(posedge mclk_i);
         #1 chk({flush_done_o, flush_busy_o, rsp_o.stall}, 3'b011);
      end
      @(posedge mclk_i);
      req_i <= '0;
      #1 chk({flush_done_o, flush_busy_o}, 2'b10);
      chk({rsp_o.commit, rsp_o.stall}, 2'b10);
      @(posedge mclk_i);
      #1 chk({flush_done_o, flush_busy_o, rsp_o.commit}, 3'b000);
   endtask

   initial begin
      err_total = 0;
      n_compared = 0;
      sys_rst_i = 1'b1;
      reg_addr_i = '0;
      reg_wdata_i = '0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      req_i = '0;
      repeat (16) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      t_reset_vals();
      t_window_regs();
      t_unmapped();
      t_model();
      t_instr();
      t_asi();
      t_pc_mask();
      t_flush();
      end_of_test();
   end
endmodule // core_impl_dependency_control_test

bind core_impl_dependency_control core_impl_dependency_control_props #(
   .DATA_W(DATA_W), .ADDR_W(ADDR_W), .FLUSH_CYCLES(FLUSH_CYCLES)) u_props (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_i(req_i),
   .rsp_o(rsp_o), .flush_done_o(flush_done_o), .mem_model_o(mem_model_o), .cwp_o(cwp_o),
   .red_vec_va_o(red_vec_va_o), .red_vec_pa_o(red_vec_pa_o));
`default_nettype wire
